// *** rtl/tkd_core.sv ***
module tkd_core (
  input  wire logic                     core_clk_in,
  input  wire logic                     rst_n_in,
  input  wire tkd_pkg::tkd_key_cfg_s [15:0] key_cfg_in,
  input  wire tkd_pkg::tkd_glb_cfg_s    glb_cfg_in,
  input  wire logic                     ramp_cmp_in,
  output logic [3:0]                    row_drive_out,
  output logic [1:0]                    col_sel_out,
  output logic                          ramp_en_out,
  output logic [15:0]                   sample_out,
  output logic [15:0]                   ref_out,
  output logic [3:0]                    sample_key_out,
  output logic                          sample_valid_out,
  output logic [15:0]                   touch_out
);

  // ==========================================================
  // declarations
  tkd_pkg::tkd_state_e   st_r;
  logic [3:0]            key_r;
  logic [7:0]            div_r;
  logic                  phase_r;
  logic [7:0]            burst_r;
  logic [15:0]           ramp_r;
  logic [15:0]           samp_r;
  logic [15:0]           ref_r   [tkd_pkg::KEYS];
  logic [3:0]            int_r   [tkd_pkg::KEYS];
  logic [7:0]            pcnt_r  [tkd_pkg::KEYS];
  logic [7:0]            dcnt_r  [tkd_pkg::KEYS];
  logic                  tch_r   [tkd_pkg::KEYS];
  logic                  pact_r  [tkd_pkg::KEYS];
  logic                  cal_r   [tkd_pkg::KEYS];
  tkd_pkg::tkd_key_cfg_s cfg;
  logic                  ct_en;
  logic                  burst_done;
  logic [7:0]            blen;
  logic [15:0]           ref_c;
  logic [16:0]           s17;
  logic [16:0]           r17;
  logic [16:0]           nthr;
  logic [16:0]           pthr;
  logic [16:0]           nhold;
  logic [16:0]           phold;
  logic                  det_w;
  logic                  pos_w;
  logic                  fast_w;
  logic [15:0]           ref_nxt;
  logic [3:0]            int_nxt;
  logic [7:0]            pcnt_nxt;
  logic [7:0]            dcnt_nxt;
  logic                  tch_nxt;
  logic                  proc_w;

  function automatic logic [2:0] hys_sh(input tkd_pkg::tkd_hys_e h);
    unique case (h)
      tkd_pkg::HYS_12P5: hys_sh = tkd_pkg::SH_12P5;
      tkd_pkg::HYS_25:   hys_sh = tkd_pkg::SH_25;
      default:           hys_sh = tkd_pkg::SH_50;
    endcase
  endfunction : hys_sh

  // ==========================================================
  // burst timing
  assign cfg        = key_cfg_in[key_r];
  assign blen       = (cfg.burst_len == 8'h00) ? 8'h01 : cfg.burst_len;
  assign ct_en      = (div_r == tkd_pkg::CT_HALF - 8'h01);
  assign burst_done = ct_en && phase_r && (burst_r + 8'h01 >= blen);
  assign proc_w     = (st_r == tkd_pkg::ST_PROC);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_r <= 8'h00;
    end else if (st_r != tkd_pkg::ST_BURST || ct_en) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // ==========================================================
  // scan sequencer
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r          <= tkd_pkg::ST_BURST;
      key_r         <= tkd_pkg::KEY_FIRST;
      phase_r       <= 1'b0;
      burst_r       <= 8'h00;
      ramp_r        <= 16'h0000;
      samp_r        <= 16'h0000;
      row_drive_out <= 4'h0;
      col_sel_out   <= 2'h0;
      ramp_en_out   <= 1'b0;
    end else begin
      unique case (st_r)
        tkd_pkg::ST_BURST: begin
          col_sel_out <= key_r[1:0];
          if (ct_en) begin
            phase_r       <= ~phase_r;
            row_drive_out <= phase_r ? 4'h0 : 4'(4'h1 << key_r[3:2]);
            if (phase_r) begin
              burst_r <= burst_r + 8'h01;
            end
            if (burst_done) begin
              st_r        <= tkd_pkg::ST_CONV;
              burst_r     <= 8'h00;
              ramp_r      <= 16'h0000;
              ramp_en_out <= 1'b1;
            end
          end
        end
        tkd_pkg::ST_CONV: begin
          if (ramp_cmp_in || ramp_r == tkd_pkg::RAMP_MAX) begin
            samp_r      <= ramp_r;
            ramp_en_out <= 1'b0;
            st_r        <= tkd_pkg::ST_PROC;
          end else begin
            ramp_r <= ramp_r + 16'h0001;
          end
        end
        tkd_pkg::ST_PROC: begin
          key_r <= key_r + 4'h1;
          st_r  <= tkd_pkg::ST_BURST;
        end
        default: begin
          st_r <= tkd_pkg::ST_BURST;
        end
      endcase
    end
  end

  // ==========================================================
  // levels from the current reference
  always_comb begin
    ref_c = ref_r[key_r];
    s17   = {1'b0, samp_r};
    r17   = {1'b0, ref_c};
    nthr  = {9'h000, cfg.neg_thr};
    pthr  = {9'h000, cfg.pos_thr};
    nhold = nthr - (nthr >> hys_sh(glb_cfg_in.hys_neg));
    phold = pthr - (pthr >> hys_sh(glb_cfg_in.hys_pos));
    // touch drives the sample below the reference
    det_w = tch_r[key_r] ? (s17 + nhold < r17)
                         : (s17 + nthr <= r17);
    pos_w = pact_r[key_r] ? (s17 > r17 + phold)
                          : (s17 > r17 + pthr);
    fast_w = cal_r[key_r] && pos_w && cfg.pos_dly != 8'h00
             && pcnt_r[key_r] + 8'h01 >= cfg.pos_dly;
  end

  // ==========================================================
  // integrator, recalibration and drift
  always_comb begin
    int_nxt  = int_r[key_r];
    tch_nxt  = tch_r[key_r];
    ref_nxt  = ref_c;
    pcnt_nxt = 8'h00;
    dcnt_nxt = 8'h00;
    if (cfg.det_lim == 4'h0) begin
      int_nxt = 4'h0;
      tch_nxt = 1'b0;
    end else if (!tch_r[key_r]) begin
      if (!det_w) begin
        int_nxt = 4'h0;
      end else if (int_r[key_r] + 4'h1 >= cfg.det_lim) begin
        int_nxt = cfg.det_lim;
        tch_nxt = 1'b1;
      end else begin
        int_nxt = int_r[key_r] + 4'h1;
      end
    end else if (det_w) begin
      int_nxt = cfg.det_lim;
    end else if (int_r[key_r] <= 4'h1) begin
      int_nxt = 4'h0;
      tch_nxt = 1'b0;
    end else begin
      int_nxt = int_r[key_r] - 4'h1;
    end
    if (!cal_r[key_r] || fast_w) begin
      ref_nxt = samp_r;
    end else begin
      if (pos_w && cfg.pos_dly != 8'h00) begin
        pcnt_nxt = pcnt_r[key_r] + 8'h01;
      end
      if (!det_w && !tch_r[key_r]) begin
        if (samp_r > ref_c && cfg.drift_up != 8'h00) begin
          if (dcnt_r[key_r] + 8'h01 >= cfg.drift_up) begin
            ref_nxt = ref_c + 16'h0001;
          end else begin
            dcnt_nxt = dcnt_r[key_r] + 8'h01;
          end
        end else if (samp_r < ref_c && cfg.drift_dn != 8'h00) begin
          if (dcnt_r[key_r] + 8'h01 >= cfg.drift_dn) begin
            ref_nxt = ref_c - 16'h0001;
          end else begin
            dcnt_nxt = dcnt_r[key_r] + 8'h01;
          end
        end
      end
    end
  end

  // ==========================================================
  // per-key state
  for (genvar k = 0; k < tkd_pkg::KEYS; k++) begin : g_key
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        ref_r[k]  <= tkd_pkg::REF_RST;
        int_r[k]  <= 4'h0;
        pcnt_r[k] <= 8'h00;
        dcnt_r[k] <= 8'h00;
        tch_r[k]  <= 1'b0;
        pact_r[k] <= 1'b0;
        cal_r[k]  <= 1'b0;
      end else if (proc_w && key_r == 4'(k)) begin
        ref_r[k]  <= ref_nxt;
        int_r[k]  <= int_nxt;
        pcnt_r[k] <= pcnt_nxt;
        dcnt_r[k] <= dcnt_nxt;
        tch_r[k]  <= tch_nxt;
        pact_r[k] <= pos_w && !fast_w;
        cal_r[k]  <= 1'b1;
      end
    end
    assign touch_out[k] = tch_r[k];
  end

  // ==========================================================
  // sample report
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sample_out       <= 16'h0000;
      ref_out          <= 16'h0000;
      sample_key_out   <= 4'h0;
      sample_valid_out <= 1'b0;
    end else begin
      sample_valid_out <= proc_w;
      if (proc_w) begin
        sample_out     <= samp_r;
        ref_out        <= ref_nxt;
        sample_key_out <= key_r;
      end
    end
  end

  // ==========================================================
  // checks
  logic       seen_r;
  logic [3:0] last_r;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seen_r <= 1'b0;
      last_r <= 4'h0;
    end else if (sample_valid_out) begin
      seen_r <= 1'b1;
      last_r <= sample_key_out;
    end
  end

  a_scan_order: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    sample_valid_out && seen_r |-> sample_key_out == last_r + 4'h1)
    else $error("keys not scanned in order");

  a_row_single: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $onehot0(row_drive_out) && !(ramp_en_out && row_drive_out != 4'h0))
    else $error("more than one row driven");

  a_conv_once: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $fell(ramp_en_out) |-> proc_w ##1 sample_valid_out)
    else $error("conversion did not yield one sample");

  a_touch_cause: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    proc_w && !tch_r[key_r] && !det_w |=> !touch_out[$past(key_r)])
    else $error("touch without threshold crossing");

  a_int_disable: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    proc_w && cfg.det_lim == 4'h0 |=> !touch_out[$past(key_r)])
    else $error("disabled key reports touch");

  a_hyst_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    proc_w && tch_r[key_r] && cfg.det_lim != 4'h0 && s17 + nhold < r17
    |=> touch_out[$past(key_r)])
    else $error("touch dropped inside hysteresis");

  a_drift_freeze: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    proc_w && cal_r[key_r] && det_w |=> ref_out == $past(ref_c))
    else $error("reference moved during detection");

  a_drift_step: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    proc_w && cal_r[key_r] && !fast_w
    |=> ref_out == $past(ref_c) || ref_out == $past(ref_c) + 16'h0001
        || ref_out == $past(ref_c) - 16'h0001)
    else $error("reference stepped more than one count");

  a_fast_recal: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    proc_w && fast_w |=> ref_out == sample_out && sample_valid_out)
    else $error("fast recalibration missed");

  a_valid_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    sample_valid_out |=> !sample_valid_out)
    else $error("sample valid longer than one cycle");

  a_row_match: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    row_drive_out != 4'h0 |-> row_drive_out == 4'(4'h1 << key_r[3:2]))
    else $error("driven row does not match scanned key");

  a_col_select: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ramp_en_out |-> col_sel_out == key_r[1:0])
    else $error("sense column does not match scanned key");

  a_touch_confirm: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    proc_w && !tch_r[key_r] && int_r[key_r] + 4'h1 < cfg.det_lim
    |=> !touch_out[$past(key_r)])
    else $error("touch confirmed before integrator limit");

  a_drift_off: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    proc_w && cal_r[key_r] && !fast_w && cfg.drift_up == 8'h00 && cfg.drift_dn == 8'h00
    |=> ref_out == $past(ref_c))
    else $error("reference drifted with drift disabled");

endmodule : tkd_core

// *** rtl/tkd_pkg.sv ***
package tkd_pkg;

  // ==========================================================
  // matrix geometry and sample width
  localparam int          KEYS        = 16;
  localparam int          ROWS        = 4;
  localparam int          COLS        = 4;
  localparam int          SW          = 16;

  // ==========================================================
  // timing
  localparam int          CLK_NS      = 40;
  localparam int          CT_HALF_NS  = 500;
  localparam int          CT_HALF_CYC = (CT_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  CT_HALF     = 8'(CT_HALF_CYC);
  localparam logic [15:0] RAMP_MAX    = 16'hFFFF;

  // ==========================================================
  // hysteresis shifts: drop-out distance = thr - (thr >> shift)
  localparam logic [2:0]  SH_12P5     = 3'h3;
  localparam logic [2:0]  SH_25       = 3'h2;
  localparam logic [2:0]  SH_50       = 3'h1;

  // ==========================================================
  // reset values
  localparam logic [15:0] REF_RST     = 16'h0000;
  localparam logic [3:0]  KEY_FIRST   = 4'h0;

  typedef enum logic [1:0] {
    HYS_12P5,
    HYS_25,
    HYS_50,
    HYS_RSV
  } tkd_hys_e;

  typedef enum logic [1:0] {
    ST_BURST,
    ST_CONV,
    ST_PROC
  } tkd_state_e;

  typedef struct packed {
    logic [7:0] neg_thr;
    logic [7:0] pos_thr;
    logic [7:0] burst_len;
    logic [7:0] drift_up;
    logic [7:0] drift_dn;
    logic [7:0] pos_dly;
    logic [3:0] det_lim;
  } tkd_key_cfg_s;

  typedef struct packed {
    tkd_hys_e hys_neg;
    tkd_hys_e hys_pos;
  } tkd_glb_cfg_s;

endpackage : tkd_pkg

// *** verification/tkd_core_test.sv ***
module tkd_core_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic                         core_clk_in = 1'b0;
  logic                         rst_n_in    = 1'b0;
  tkd_pkg::tkd_key_cfg_s [15:0] key_cfg;
  tkd_pkg::tkd_glb_cfg_s        glb_cfg;
  logic                         ramp_cmp;
  logic [3:0]                   row_drive;
  logic [1:0]                   col_sel;
  logic                         ramp_en;
  logic [15:0]                  sample;
  logic [15:0]                  ref_val;
  logic [3:0]                   sample_key;
  logic                         sample_valid;
  logic [15:0]                  touch;
  logic [7:0]                   pulses;
  logic [15:0][15:0]            level;
  logic [15:0]                  smp [16];
  logic [15:0]                  rf  [16];
  int                           n_fail   = 0;
  int                           n_checks = 0;

  always #20 core_clk_in = ~core_clk_in;

  tkd_core i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .key_cfg_in(key_cfg),
    .glb_cfg_in(glb_cfg), .ramp_cmp_in(ramp_cmp), .row_drive_out(row_drive),
    .col_sel_out(col_sel), .ramp_en_out(ramp_en), .sample_out(sample), .ref_out(ref_val),
    .sample_key_out(sample_key), .sample_valid_out(sample_valid), .touch_out(touch));

  tkd_front_end i_front (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .row_drive_in(row_drive), .col_sel_in(col_sel), .ramp_en_in(ramp_en),
    .level_in(level), .ramp_cmp_out(ramp_cmp), .pulses_out(pulses));

  // ==========================================================
  // shared tasks
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic wait_valid(output logic [3:0] k);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge core_clk_in);
      #1;
      if (sample_valid === 1'b1) break;
    end
    if (i == 3000) begin
      n_fail++;
      complete_run();
    end
    k = sample_key;
    smp[k] = sample;
    rf[k] = ref_val;
  endtask : wait_valid

  task automatic wait_key(input logic [3:0] k, input int n);
    logic [3:0] got;
    repeat (n) begin
      got = ~k;
      for (int j = 0; j < 17 && got !== k; j++) wait_valid(got);
      check("scan key", {12'h000, got}, {12'h000, k});
    end
  endtask : wait_key

  // sample of key k lands at reference plus d
  task automatic set_dev(input logic [3:0] k, input int d);
    @(posedge core_clk_in);
    level[k] <= level[k] + rf[k] - smp[k] + 16'(d);
  endtask : set_dev

  // ==========================================================
  // scenarios
  task automatic t_scan();
    logic [3:0] k;
    wait_valid(k);
    check("first key", {12'h000, k}, 16'h0000);
    check("sample", smp[k], 16'h0028);
    check("calib ref", rf[k], 16'h0028);
    for (int i = 1; i < 16; i++) begin
      wait_valid(k);
      check("scan order", {12'h000, k}, 16'(i));
      check("sample", smp[k], 16'h0028);
      if (i == 3 || i == 4) check("pulses", {8'h00, pulses}, i == 3 ? 16'h0003 : 16'h0001);
    end
  endtask : t_scan

  task automatic t_touch();
    logic [15:0] r0;
    r0 = rf[5];
    set_dev(5, -20);
    set_dev(6, -19);
    set_dev(14, -30);
    wait_key(5, 2);
    check("touch early", touch, 16'h0000);
    wait_key(5, 1);
    wait_key(6, 1);
    check("touch set", touch, 16'h0020);
    check("disabled key", {15'h0000, touch[14]}, 16'h0000);
    check("ref frozen", rf[5], r0);
    set_dev(5, 0);
    set_dev(6, 0);
    set_dev(14, 0);
    wait_key(5, 4);
    check("touch gone", touch, 16'h0000);
    set_dev(5, -20);
    wait_key(5, 2);
    set_dev(5, 0);
    wait_key(5, 1);
    set_dev(5, -20);
    wait_key(5, 2);
    check("miss clears", touch, 16'h0000);
    set_dev(5, 0);
  endtask : t_touch

  task automatic t_hyst();
    int d;
    for (int h = 0; h < 4; h++) begin
      d = 32 - (32 >> (h == 0 ? 3 : (h == 1 ? 2 : 1)));
      @(posedge core_clk_in);
      glb_cfg.hys_neg <= tkd_pkg::tkd_hys_e'(h[1:0]);
      set_dev(7, -32);
      wait_key(7, 1);
      check("hys on", touch, 16'h0080);
      set_dev(7, -d - 1);
      wait_key(7, 2);
      check("hys hold", touch, 16'h0080);
      set_dev(7, -d);
      wait_key(7, 2);
      check("hys drop", touch, 16'h0000);
    end
    set_dev(7, 0);
  endtask : t_hyst

  task automatic t_pos();
    logic [15:0] r0;
    for (int p = 0; p < 2; p++) begin
      @(posedge core_clk_in);
      glb_cfg.hys_pos <= p == 0 ? tkd_pkg::HYS_12P5 : tkd_pkg::HYS_50;
      glb_cfg.hys_neg <= p == 0 ? tkd_pkg::HYS_50 : tkd_pkg::HYS_12P5;
      r0 = rf[9];
      set_dev(9, 17);
      wait_key(9, 1);
      set_dev(9, 13);
      wait_key(9, 1);
      check("pos wait", rf[9], r0);
      set_dev(9, 17);
      wait_key(9, 1);
      check("pos recal", rf[9], p == 0 ? r0 : smp[9]);
      set_dev(9, 0);
      wait_key(9, 1);
    end
  endtask : t_pos

  task automatic t_drift();
    logic [15:0] r0;
    logic [15:0] r1;
    r0 = rf[12];
    r1 = rf[13];
    set_dev(12, 3);
    set_dev(13, 3);
    wait_key(12, 1);
    check("drift wait", rf[12], r0);
    wait_key(12, 1);
    check("drift up", rf[12], r0 + 16'h0001);
    wait_key(12, 4);
    check("drift settle", rf[12], smp[12]);
    check("drift off", rf[13], r1);
    set_dev(12, -3);
    wait_key(12, 3);
    check("drift dn wait", rf[12], r0 + 16'h0003);
    wait_key(12, 1);
    check("drift dn", rf[12], r0 + 16'h0002);
    set_dev(12, -20);
    wait_key(12, 2);
    check("thr follows", touch, 16'h1000);
    set_dev(12, 0);
  endtask : t_drift

  // ==========================================================
  // main sequence
  initial begin
    for (int k = 0; k < 16; k++) begin
      key_cfg[k] = '{8'h14, 8'h10, 8'h01, 8'h00, 8'h00, 8'h00, 4'h2};
      level[k] = 16'h0028;
    end
    key_cfg[3].burst_len = 8'h03;
    key_cfg[4].burst_len = 8'h00;
    key_cfg[14].det_lim = 4'h0;
    key_cfg[5].det_lim = 4'h3;
    key_cfg[5].drift_dn = 8'h01;
    key_cfg[6].det_lim = 4'h3;
    key_cfg[7].neg_thr = 8'h20;
    key_cfg[7].det_lim = 4'h1;
    key_cfg[9].pos_dly = 8'h03;
    key_cfg[12].drift_up = 8'h02;
    key_cfg[12].drift_dn = 8'h04;
    glb_cfg = '{tkd_pkg::HYS_12P5, tkd_pkg::HYS_12P5};
    repeat (4) @(posedge core_clk_in);
    check("reset touch", touch, 16'h0000);
    rst_n_in <= 1'b1;
    t_scan();
    t_touch();
    t_hyst();
    t_pos();
    t_drift();
    complete_run();
  end
endmodule : tkd_core_test

// *** verification/tkd_front_end.sv ***
module tkd_front_end (
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic [3:0]            row_drive_in,
  input  wire logic [1:0]            col_sel_in,
  input  wire logic                  ramp_en_in,
  input  wire logic [15:0][15:0]     level_in,
  output logic                       ramp_cmp_out,
  output logic [7:0]                 pulses_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] ramp_r;
  logic [3:0]  row_r;
  logic [1:0]  row_idx_r;
  logic [7:0]  acc_r;
  logic        toggle_r;

  // ==========================================================
  // comparator, noisy while no conversion runs
  assign ramp_cmp_out = ramp_en_in ? (ramp_r >= level_in[{row_idx_r, col_sel_in}])
                                   : toggle_r;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ramp_r     <= 16'h0000;
      row_r      <= 4'h0;
      row_idx_r  <= 2'h0;
      acc_r      <= 8'h00;
      toggle_r   <= 1'b0;
      pulses_out <= 8'h00;
    end else begin
      toggle_r <= ~toggle_r;
      row_r    <= row_drive_in;
      ramp_r   <= ramp_en_in ? ramp_r + 16'h0001 : 16'h0000;
      if (|row_drive_in) begin
        row_idx_r <= {row_drive_in[3] | row_drive_in[2], row_drive_in[3] | row_drive_in[1]};
      end
      if (|row_drive_in && row_r == 4'h0) begin
        acc_r <= acc_r + 8'h01;
      end
      if (ramp_en_in && ramp_r == 16'h0000) begin
        pulses_out <= acc_r;
        acc_r      <= 8'h00;
      end
    end
  end
endmodule : tkd_front_end
